// ==== dv/radio_synth_lock_control_tb_top.sv ====
`timescale 1ns/1ns
module radio_synth_lock_control_tb_top;
    localparam logic [15:0] T_ST = 16'h0032;
    logic sys_clk, rst_n, fault, wr, rd;
    logic [3:0] cmd_state, trx_state;
    logic synth_locked, synth_enable, cf_run, dcu_run, tx_sel, tx_ready, lock_ev, unlock_ev, irq;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [11:0] carrier;
    logic lock_d = 1'b0;
    logic unlock_d = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_lock = 0;
    int n_unlock = 0;
    int t0, nl, nu;

    rslc_top #(.T_START_CYC(T_ST)) u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_trx_state(trx_state), .i_synth_locked(synth_locked), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_synth_enable(synth_enable),
        .o_cf_cal_run(cf_run), .o_dcu_cal_run(dcu_run), .o_tx_freq_sel(tx_sel),
        .o_tx_freq_ready(tx_ready), .o_carrier_mhz(carrier), .o_lock_event(lock_ev),
        .o_unlock_event(unlock_ev), .o_irq(irq));
    rslc_far_model u_far (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cmd_state(cmd_state),
        .i_unlock_fault(fault), .i_synth_enable(synth_enable), .o_trx_state(trx_state),
        .o_synth_locked(synth_locked));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Event monitor and hang guard
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        lock_d <= lock_ev;
        unlock_d <= unlock_ev;
        if (lock_ev === 1'b1) n_lock <= n_lock + 1;
        if (unlock_ev === 1'b1) n_unlock <= n_unlock + 1;
        if ((lock_ev & lock_d) === 1'b1 || (unlock_ev & unlock_d) === 1'b1) begin
            n_fail++;
            $display("FAIL event_width expected 1 cycle got more");
        end
        if (cycles == 40000) begin
            n_fail++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("FAIL %s expected %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
        t0 = cycles;
    endtask

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic set_state(input logic [3:0] s);
        @(posedge sys_clk);
        cmd_state <= s;
        #1;
        t0 = cycles;
    endtask

    // Bounded wait: 0 lock event, 1 unlock event, 2 tx frequency ready
    task automatic wait_ev(input int sel, input int lim);
        int n;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (!(sel == 0 ? lock_ev === 1'b1 : sel == 1 ? unlock_ev === 1'b1
                     : tx_ready === 1'b1) && n < lim);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cmd_state = rslc_pkg::ST_TRANSCEIVER_OFF;
        fault = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        chk("carrier_reset", 16'h0965, {4'h0, carrier});
        rd_chk("chan_reset", rslc_pkg::ADDR_CARRIER_SELECT, 8'h0b);
        rd_chk("fsm_off", rslc_pkg::ADDR_SYNTH_STATUS, 8'h01);
        rd_chk("unmapped", 3'h7, 8'h00);
        wr_reg(rslc_pkg::ADDR_CENTRE_FREQ_CAL, 8'h80);
        chk("start_refused_off", 16'h0000, {15'h0, cf_run});
        set_state(rslc_pkg::ST_SYNTH_ON);
        tick(2);
        chk("startup_runs", 16'h0007, {13'h0, synth_enable, cf_run, dcu_run});
        wait_ev(0, 200);
        chk_rng("startup_cycles", 50, 56, cycles - t0);
        chk("startup_done", 16'h0002, {14'h0, lock_ev, cf_run});
        rd_chk("lock_status", rslc_pkg::ADDR_IRQ_STATUS, 8'h01);
        chk("irq_masked", 16'h0000, {15'h0, irq});
        wr_reg(rslc_pkg::ADDR_IRQ_MASK, 8'h03);
        chk("irq_unmasked", 16'h0001, {15'h0, irq});
        wr_reg(rslc_pkg::ADDR_IRQ_STATUS, 8'h01);
        chk("irq_cleared", 16'h0000, {15'h0, irq});
        for (int i = 1; i <= 16; i++) begin
            wr_reg(rslc_pkg::ADDR_CARRIER_SELECT, 8'(11 + i % 16));
            chk("carrier", {4'h0, rslc_pkg::FREQ_BASE_MHZ + 12'(5 * (i % 16))}, {4'h0, carrier});
            chk("retune_run", 16'h0001, {15'h0, cf_run});
            wait_ev(0, 1300);
            chk_rng("retune_cycles", 1095, 1106, cycles - t0);
        end
        wr_reg(rslc_pkg::ADDR_CARRIER_SELECT, 8'h1b);
        wr_reg(rslc_pkg::ADDR_CARRIER_SELECT, 8'h0a);
        chk("chan_refused", 16'h0965, {4'h0, carrier});
        wr_reg(rslc_pkg::ADDR_CENTRE_FREQ_CAL, 8'h80);
        wr_reg(rslc_pkg::ADDR_DELAY_CELL_CAL, 8'h80);
        chk("both_runs", 16'h0003, {14'h0, cf_run, dcu_run});
        rd_chk("cf_busy", rslc_pkg::ADDR_CENTRE_FREQ_CAL, 8'h80);
        rd_chk("dcu_busy", rslc_pkg::ADDR_DELAY_CELL_CAL, 8'h80);
        wait_ev(0, 1300);
        chk_rng("manual_cycles", 1090, 1106, cycles - t0);
        tick(10);
        rd_chk("cf_done", rslc_pkg::ADDR_CENTRE_FREQ_CAL, 8'h00);
        rd_chk("dcu_done", rslc_pkg::ADDR_DELAY_CELL_CAL, 8'h00);
        nl = n_lock;
        nu = n_unlock;
        set_state(rslc_pkg::ST_BUSY_TRANSMIT);
        wr_reg(rslc_pkg::ADDR_DELAY_CELL_CAL, 8'h80);
        chk("tx_shift", 16'h0002, {14'h0, tx_sel, dcu_run});
        fault <= 1'b1;
        wait_ev(2, 1800);
        chk_rng("tx_shift_cycles", 1596, 1606, cycles - t0);
        set_state(rslc_pkg::ST_SYNTH_ON);
        tick(5);
        chk("tx_off", 16'h0000, {15'h0, tx_sel});
        rd_chk("rx_return", rslc_pkg::ADDR_SYNTH_STATUS, 8'h10);
        fault <= 1'b0;
        tick(3100);
        rd_chk("rx_return_end", rslc_pkg::ADDR_SYNTH_STATUS, 8'h10);
        tick(100);
        rd_chk("back_on", rslc_pkg::ADDR_SYNTH_STATUS, 8'h02);
        chk("no_tx_events", 16'(n_lock - nl), 16'(n_unlock - nu));
        chk("no_tx_lock", 16'h0000, 16'(n_lock - nl));
        wr_reg(rslc_pkg::ADDR_IRQ_STATUS, 8'h03);
        fault <= 1'b1;
        t0 = cycles;
        wait_ev(1, 20);
        chk_rng("unlock_cycles", 3, 7, cycles - t0);
        tick(1);
        rd_chk("unlock_status", rslc_pkg::ADDR_IRQ_STATUS, 8'h02);
        chk("unlock_irq", 16'h0001, {15'h0, irq});
        fault <= 1'b0;
        set_state(rslc_pkg::ST_TRANSCEIVER_OFF);
        tick(2);
        chk("off", 16'h0000, {13'h0, synth_enable, cf_run, dcu_run});
        end_sim();
    end
endmodule

// ==== dv/rslc_far_model.sv ====
`timescale 1ns/1ns
module rslc_far_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_cmd_state,
    input wire logic i_unlock_fault,
    input wire logic i_synth_enable,
    output logic [3:0] o_trx_state,
    output logic o_synth_locked
);
    // ----------------------------------------------------------------
    // State controller and analog loop stand-in
    // ----------------------------------------------------------------
    logic [3:0] settle_reg;

    assign o_trx_state = i_cmd_state;

    // Lock comes some cycles after enable, never at once
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_reg <= 4'h0;
        end else if (!i_synth_enable) begin
            settle_reg <= 4'h0;
        end else if (settle_reg != 4'h8) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end

    // Fault input lets the bench pull lock away on purpose
    assign o_synth_locked = (settle_reg == 4'h8) && !i_unlock_fault;
endmodule

// ==== hw/rslc_top.sv ====
`timescale 1ns/1ns
// What this block does
// [R1] Off to synth-on: settle 110 us, then lock
// [R2] Retune to new channel within 11 us
// [R3] Tx shift 16 us, return 32 us
// [R4] No lock/unlock events during tx steps
// [R5] Enable launches both calibration loops
// [R6] Channel change relaunches centre-frequency loop; code does so only in RSLC_ON, not when off or in tx steps
// [R7] Writing start bit one launches its loop
// [R8] Manual start only in synth-on or receive-on
// [R9] Centre-frequency loop completion raises lock event; code raises it only when completion lands in RSLC_ON
// [R10] Both loops run concurrently and independently
// [R11] Unexpected lock loss raises unlock event
// [R12] Lock event on enable and channel change; code raises it on channel change only in RSLC_ON
// [R13] No lock event settling back after transmit
// [R14] Software treats other events as errors
// [R15] Sixteen channels 11..26, 5 MHz spacing
// [R16] Carrier is 2405 plus 5(k-11) MHz
// [R17] Software recalibrates after long dwell, temperature
// [R18] Lock/unlock events are one-cycle pulses
// [R19] Start bits read one while loop runs
module rslc_top #(
    parameter logic [rslc_pkg::CNT_W-1:0] T_START_CYC = rslc_pkg::T_START_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_trx_state,
    input wire logic i_synth_locked,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_synth_enable,
    output logic o_cf_cal_run,
    output logic o_dcu_cal_run,
    output logic o_tx_freq_sel,
    output logic o_tx_freq_ready,
    output logic [11:0] o_carrier_mhz,
    output logic o_lock_event,
    output logic o_unlock_event,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_on_state(input logic [3:0] s);
        is_on_state = (s == rslc_pkg::ST_SYNTH_ON) || (s == rslc_pkg::ST_RECEIVE_ON) ||
                      (s == rslc_pkg::ST_AUTO_ACK_RECEIVE) ||
                      (s == rslc_pkg::ST_AUTO_RETRY_TRANSMIT);
    endfunction

    function automatic logic [11:0] chan_to_mhz(input logic [4:0] k);
        logic [11:0] idx;
        idx = 12'({7'h00, k} - {7'h00, rslc_pkg::CHAN_MIN});
        chan_to_mhz = 12'(rslc_pkg::FREQ_BASE_MHZ + idx * rslc_pkg::CHAN_SPACING_MHZ);
    endfunction

    function automatic logic [rslc_pkg::CNT_W-1:0] dec(input logic [rslc_pkg::CNT_W-1:0] c);
        dec = (c != '0) ? rslc_pkg::CNT_W'(c - 1'b1) : c;
    endfunction

    rslc_pkg::rslc_state_s r_reg;
    rslc_pkg::rslc_state_s r_next;

    logic wr_chan;
    logic chan_legal;
    logic chan_changes;
    logic manual_ok;
    logic wr_cf_start;
    logic wr_dcu_start;
    logic going_off;

    assign wr_chan = i_wr && (i_addr == rslc_pkg::ADDR_CARRIER_SELECT);
    assign chan_legal = (i_wdata[4:0] >= rslc_pkg::CHAN_MIN) &&
                        (i_wdata[4:0] <= rslc_pkg::CHAN_MAX) && (i_wdata[7:5] == 3'h0);
    assign chan_changes = wr_chan && chan_legal && (i_wdata[4:0] != r_reg.chan);
    // Calibration writes from other states are dropped silently
    assign manual_ok = (r_reg.fsm == rslc_pkg::RSLC_ON) &&
                       ((i_trx_state == rslc_pkg::ST_SYNTH_ON) ||
                        (i_trx_state == rslc_pkg::ST_RECEIVE_ON)); // R8
    assign wr_cf_start = i_wr && (i_addr == rslc_pkg::ADDR_CENTRE_FREQ_CAL) &&
                         i_wdata[rslc_pkg::CAL_START_BIT] && manual_ok; // R7
    assign wr_dcu_start = i_wr && (i_addr == rslc_pkg::ADDR_DELAY_CELL_CAL) &&
                          i_wdata[rslc_pkg::CAL_START_BIT] && manual_ok; // R7
    assign going_off = (i_trx_state == rslc_pkg::ST_TRANSCEIVER_OFF) &&
                       (r_reg.fsm != rslc_pkg::RSLC_OFF);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic lock_set;
        logic unlock_set;
        lock_set = 1'b0;
        unlock_set = 1'b0;
        r_next = r_reg;
        r_next.lock_ev = 1'b0;
        r_next.unlock_ev = 1'b0;
        r_next.lock_s1 = i_synth_locked;
        r_next.lock_s2 = r_reg.lock_s1;
        r_next.lock_prev = r_reg.lock_s2;
        r_next.trx_prev = i_trx_state;
        r_next.rdata = 8'h00;

        // Independent down-counters, so neither loop waits on the other
        r_next.step_cnt = dec(r_reg.step_cnt);
        r_next.cf_cnt = dec(r_reg.cf_cnt); // R10
        r_next.dcu_cnt = dec(r_reg.dcu_cnt); // R10
        if (r_reg.cf_cnt == rslc_pkg::CNT_W'(1) && r_reg.fsm == rslc_pkg::RSLC_ON) begin
            lock_set = 1'b1; // R9 R12
        end

        case (r_reg.fsm)
            rslc_pkg::RSLC_OFF: begin
                if (is_on_state(i_trx_state) &&
                    r_reg.trx_prev == rslc_pkg::ST_TRANSCEIVER_OFF) begin
                    r_next.fsm = rslc_pkg::RSLC_ON;
                    r_next.cf_cnt = T_START_CYC; // R1 R5
                    r_next.dcu_cnt = T_START_CYC; // R5
                end
            end
            rslc_pkg::RSLC_ON: begin
                if (i_trx_state == rslc_pkg::ST_BUSY_TRANSMIT &&
                    r_reg.trx_prev != rslc_pkg::ST_BUSY_TRANSMIT) begin
                    r_next.fsm = rslc_pkg::RSLC_TX_SHIFT;
                    r_next.step_cnt = rslc_pkg::T_TX_SHIFT_CYC; // R3
                end
            end
            rslc_pkg::RSLC_TX_SHIFT: begin
                if (r_reg.step_cnt == rslc_pkg::CNT_W'(1)) begin
                    r_next.fsm = rslc_pkg::RSLC_TX_BUSY; // R3
                end
            end
            rslc_pkg::RSLC_TX_BUSY: begin
                if (i_trx_state != rslc_pkg::ST_BUSY_TRANSMIT) begin
                    r_next.fsm = rslc_pkg::RSLC_RX_RETURN;
                    r_next.step_cnt = rslc_pkg::T_RX_RETURN_CYC; // R3
                end
            end
            rslc_pkg::RSLC_RX_RETURN: begin
                // Settling back is silent even when it lands in synth-on
                if (r_reg.step_cnt == rslc_pkg::CNT_W'(1)) begin
                    r_next.fsm = rslc_pkg::RSLC_ON; // R13
                end
            end
            default: begin
                r_next.fsm = rslc_pkg::RSLC_OFF;
            end
        endcase

        // Lock loss only counts once settled and the centre-frequency loop is idle
        if (r_reg.fsm == rslc_pkg::RSLC_ON && r_reg.lock_prev && !r_reg.lock_s2 &&
            r_reg.cf_cnt == '0) begin
            unlock_set = 1'b1; // R11
        end

        // Register writes
        if (wr_chan && chan_legal) begin
            r_next.chan = i_wdata[4:0]; // R15
        end
        if (chan_changes && r_reg.fsm == rslc_pkg::RSLC_ON) begin
            r_next.cf_cnt = rslc_pkg::T_RETUNE_CYC; // R2 R6
        end
        if (wr_cf_start) begin
            r_next.cf_cnt = rslc_pkg::T_RETUNE_CYC; // R7
        end
        if (wr_dcu_start) begin
            r_next.dcu_cnt = rslc_pkg::T_RETUNE_CYC; // R7
        end
        if (i_wr && i_addr == rslc_pkg::ADDR_IRQ_MASK) begin
            r_next.mask = i_wdata[1:0];
        end
        if (i_wr && i_addr == rslc_pkg::ADDR_IRQ_STATUS) begin
            r_next.stat = r_reg.stat & ~i_wdata[1:0];
        end

        if (going_off) begin
            r_next.fsm = rslc_pkg::RSLC_OFF;
            r_next.step_cnt = '0;
            r_next.cf_cnt = '0;
            r_next.dcu_cnt = '0;
            unlock_set = 1'b0;
        end

        // Events only fire in the settled state; a new event beats a clear
        if (r_reg.fsm != rslc_pkg::RSLC_ON) begin
            lock_set = 1'b0; // R4
            unlock_set = 1'b0; // R4
        end
        r_next.lock_ev = lock_set; // R18
        r_next.unlock_ev = unlock_set; // R18
        r_next.stat[rslc_pkg::IRQ_LOCK_BIT] = r_next.stat[rslc_pkg::IRQ_LOCK_BIT] | lock_set;
        r_next.stat[rslc_pkg::IRQ_UNLOCK_BIT] =
            r_next.stat[rslc_pkg::IRQ_UNLOCK_BIT] | unlock_set;

        // Read data, valid in the cycle after the strobe
        if (i_rd) begin
            case (i_addr)
                rslc_pkg::ADDR_CARRIER_SELECT: r_next.rdata = {3'h0, r_reg.chan};
                rslc_pkg::ADDR_CENTRE_FREQ_CAL: r_next.rdata = {r_reg.cf_cnt != '0, 7'h00}; // R19
                rslc_pkg::ADDR_DELAY_CELL_CAL: r_next.rdata = {r_reg.dcu_cnt != '0, 7'h00}; // R19
                rslc_pkg::ADDR_IRQ_STATUS: r_next.rdata = {6'h00, r_reg.stat};
                rslc_pkg::ADDR_IRQ_MASK: r_next.rdata = {6'h00, r_reg.mask};
                rslc_pkg::ADDR_SYNTH_STATUS: r_next.rdata = {3'h0, r_reg.fsm};
                default: r_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '{fsm: rslc_pkg::RSLC_OFF, chan: rslc_pkg::CHAN_RESET,
                       trx_prev: rslc_pkg::ST_TRANSCEIVER_OFF, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata = r_reg.rdata;
    assign o_synth_enable = (r_reg.fsm != rslc_pkg::RSLC_OFF);
    assign o_cf_cal_run = (r_reg.cf_cnt != '0);
    assign o_dcu_cal_run = (r_reg.dcu_cnt != '0);
    assign o_tx_freq_sel = (r_reg.fsm == rslc_pkg::RSLC_TX_SHIFT) ||
                           (r_reg.fsm == rslc_pkg::RSLC_TX_BUSY);
    assign o_tx_freq_ready = (r_reg.fsm == rslc_pkg::RSLC_TX_BUSY); // R3
    assign o_carrier_mhz = chan_to_mhz(r_reg.chan); // R16
    assign o_lock_event = r_reg.lock_ev;
    assign o_unlock_event = r_reg.unlock_ev;
    assign o_irq = |(r_reg.stat & r_reg.mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    enable_cal_launch_a: assert property ($rose(o_synth_enable) |->
        o_cf_cal_run && o_dcu_cal_run) else $error("enable did not launch both loops"); // R5

    start_settle_len_a: assert property ($rose(o_synth_enable) |->
        r_reg.cf_cnt == T_START_CYC) else $error("startup settle length wrong"); // R1

    retune_launch_a: assert property (chan_changes && r_reg.fsm == rslc_pkg::RSLC_ON &&
        !going_off |=> r_reg.cf_cnt == rslc_pkg::T_RETUNE_CYC)
        else $error("channel change did not relaunch tuning"); // R2

    tx_shift_len_a: assert property ($rose(o_tx_freq_sel) |->
        r_reg.step_cnt == rslc_pkg::T_TX_SHIFT_CYC ##1 !o_tx_freq_ready [*8])
        else $error("tx shift timing wrong"); // R3

    rx_return_end_a: assert property (r_reg.fsm == rslc_pkg::RSLC_RX_RETURN &&
        r_reg.step_cnt == rslc_pkg::CNT_W'(1) && !going_off |=>
        r_reg.fsm == rslc_pkg::RSLC_ON) else $error("rx return did not end"); // R3

    tx_irq_quiet_a: assert property (r_reg.fsm != rslc_pkg::RSLC_ON |=>
        !o_lock_event && !o_unlock_event) else $error("event during tx step"); // R4

    cf_done_lock_a: assert property (r_reg.cf_cnt == rslc_pkg::CNT_W'(1) &&
        r_reg.fsm == rslc_pkg::RSLC_ON && !going_off |=> o_lock_event && r_reg.stat[0])
        else $error("tuning done without lock event"); // R9

    manual_refuse_a: assert property (i_wr && i_addr == rslc_pkg::ADDR_CENTRE_FREQ_CAL &&
        !manual_ok && !o_cf_cal_run && !chan_changes && r_reg.fsm != rslc_pkg::RSLC_OFF
        |=> !o_cf_cal_run) else $error("manual start accepted out of state"); // R8

    manual_accept_a: assert property (wr_dcu_start && o_cf_cal_run && !going_off |=>
        o_cf_cal_run && r_reg.dcu_cnt == rslc_pkg::T_RETUNE_CYC)
        else $error("loops blocked each other"); // R10

    unlock_event_a: assert property ($fell(r_reg.lock_s2) && r_reg.fsm == rslc_pkg::RSLC_ON
        && !o_cf_cal_run && !going_off |=> o_unlock_event)
        else $error("unlock not reported"); // R11

    event_pulse_a: assert property (o_lock_event |=> !o_lock_event)
        else $error("lock event longer than a cycle"); // R18

    start_readback_a: assert property (i_rd && i_addr == rslc_pkg::ADDR_CENTRE_FREQ_CAL |=>
        o_rdata[7] == $past(o_cf_cal_run)) else $error("start bit readback wrong"); // R19

    carrier_range_a: assert property (o_carrier_mhz >= 12'h965 && o_carrier_mhz <= 12'h9b0
        && ((o_carrier_mhz - 12'h965) % 12'h005) == 12'h000)
        else $error("carrier off channel grid"); // R15

    // ----------------------------------------------------------------
    // Boundary checks
    // ----------------------------------------------------------------
    // These guard corners and invariants, some of which the bench reaches only once

    tx_ready_sel_a: assert property ( // R3
        o_tx_freq_ready |-> o_tx_freq_sel)
        else $error("tx ready without tx frequency");

    rx_return_len_a: assert property ( // R3
        $fell(o_tx_freq_ready) && r_reg.fsm == rslc_pkg::RSLC_RX_RETURN
        |-> r_reg.step_cnt == rslc_pkg::T_RX_RETURN_CYC)
        else $error("rx return settle length wrong");

    rx_return_quiet_a: assert property ( // R13
        r_reg.fsm == rslc_pkg::RSLC_RX_RETURN
        |=> !o_lock_event)
        else $error("lock event while settling back");

    off_idle_a: assert property ( // R1
        r_reg.fsm == rslc_pkg::RSLC_OFF
        |-> !o_tx_freq_sel && !o_cf_cal_run && !o_dcu_cal_run)
        else $error("activity while synthesizer off");

    going_off_a: assert property ( // R1
        going_off
        |=> !o_synth_enable && !o_cf_cal_run && !o_dcu_cal_run)
        else $error("leaving to off did not stop loops");

    lock_status_a: assert property ( // R9
        o_lock_event
        |-> r_reg.stat[rslc_pkg::IRQ_LOCK_BIT])
        else $error("lock event without status bit");

    unlock_status_a: assert property ( // R11
        o_unlock_event
        |-> r_reg.stat[rslc_pkg::IRQ_UNLOCK_BIT])
        else $error("unlock event without status bit");

    unlock_pulse_a: assert property ( // R18
        o_unlock_event
        |=> !o_unlock_event)
        else $error("unlock event longer than a cycle");

    unlock_cal_quiet_a: assert property ( // R11
        o_cf_cal_run
        |=> !o_unlock_event)
        else $error("unlock reported during tuning");

    dcu_refuse_a: assert property ( // R8
        i_wr && i_addr == rslc_pkg::ADDR_DELAY_CELL_CAL && !manual_ok
        && !o_dcu_cal_run && r_reg.fsm != rslc_pkg::RSLC_OFF
        |=> !o_dcu_cal_run)
        else $error("delay-cell start accepted out of state");

    chan_refuse_a: assert property ( // R15
        wr_chan && !chan_legal
        |=> o_carrier_mhz == $past(o_carrier_mhz))
        else $error("illegal channel accepted");

    rdata_idle_a: assert property ( // R19
        !i_rd
        |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    startup_lock_c: cover property ($rose(o_synth_enable) ##[1:1000] o_lock_event);
    tx_cycle_c: cover property ($fell(o_tx_freq_ready) ##[1:8] !o_tx_freq_sel);
    both_cal_c: cover property (o_cf_cal_run && o_dcu_cal_run && o_tx_freq_ready);
    unlock_c: cover property (o_unlock_event);
endmodule

// ==== shared/rslc_pkg.sv ====
package rslc_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int T_START_US = 110;
    localparam int T_RETUNE_US = 11;
    localparam int T_TX_SHIFT_US = 16;
    localparam int T_RX_RETURN_US = 32;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] T_START_CYC = CNT_W'(T_START_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] T_RETUNE_CYC = CNT_W'(T_RETUNE_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] T_TX_SHIFT_CYC = CNT_W'(T_TX_SHIFT_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] T_RX_RETURN_CYC = CNT_W'(T_RX_RETURN_US * CLK_MHZ);

    // ----------------------------------------------------------------
    // Transceiver state codes from the state controller
    // ----------------------------------------------------------------
    localparam logic [3:0] ST_TRANSCEIVER_OFF = 4'h1;
    localparam logic [3:0] ST_SYNTH_ON = 4'h2;
    localparam logic [3:0] ST_RECEIVE_ON = 4'h3;
    localparam logic [3:0] ST_AUTO_ACK_RECEIVE = 4'h4;
    localparam logic [3:0] ST_AUTO_RETRY_TRANSMIT = 4'h5;
    localparam logic [3:0] ST_BUSY_TRANSMIT = 4'h6;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_CARRIER_SELECT = 3'h0;
    localparam logic [2:0] ADDR_CENTRE_FREQ_CAL = 3'h1;
    localparam logic [2:0] ADDR_DELAY_CELL_CAL = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
    localparam logic [2:0] ADDR_SYNTH_STATUS = 3'h5;
    localparam int CAL_START_BIT = 7;
    localparam int IRQ_LOCK_BIT = 0;
    localparam int IRQ_UNLOCK_BIT = 1;
    localparam logic [4:0] CHAN_MIN = 5'h0b;
    localparam logic [4:0] CHAN_MAX = 5'h1a;
    localparam logic [4:0] CHAN_RESET = 5'h0b;
    localparam logic [11:0] FREQ_BASE_MHZ = 12'h965;
    localparam logic [11:0] CHAN_SPACING_MHZ = 12'h005;

    typedef enum logic [4:0] {
        RSLC_OFF = 5'h01,
        RSLC_ON = 5'h02,
        RSLC_TX_SHIFT = 5'h04,
        RSLC_TX_BUSY = 5'h08,
        RSLC_RX_RETURN = 5'h10
    } rslc_fsm_e;

    typedef struct packed {
        rslc_fsm_e fsm;
        logic [CNT_W-1:0] step_cnt;
        logic [CNT_W-1:0] cf_cnt;
        logic [CNT_W-1:0] dcu_cnt;
        logic [4:0] chan;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [7:0] rdata;
        logic lock_s1;
        logic lock_s2;
        logic lock_prev;
        logic [3:0] trx_prev;
        logic lock_ev;
        logic unlock_ev;
    } rslc_state_s;
endpackage
